// [hdl/irq_mask_pkg.sv]
// constants and carrier types for the charger event interrupt masking block
package irq_mask_pkg;

  localparam logic [7:0] ADDR_MASK_A = 8'h12;
  localparam logic [7:0] ADDR_MASK_B = 8'h13;
  localparam logic [7:0] ADDR_MASK_F = 8'h14;
  localparam logic [7:0] ADDR_FLAG_A = 8'h0f;
  localparam logic [7:0] ADDR_FLAG_B = 8'h10;
  localparam logic [7:0] ADDR_FLAG_F = 8'h11;

  // writable positions; every other bit is reserved and reads zero
  localparam logic [7:0] USED_A = 8'hf9;
  localparam logic [7:0] USED_B = 8'h96;
  localparam logic [7:0] USED_F = 8'hd8;

  localparam logic [7:0] RESET_MASK_A = 8'h00;
  localparam logic [7:0] RESET_MASK_B = 8'h00;
  localparam logic [7:0] RESET_MASK_F = 8'h00;

  // field positions (same positions in mask and flag registers)
  localparam int BIT_ADC_DONE  = 7;
  localparam int BIT_IN_CUR    = 6;
  localparam int BIT_IN_VOLT   = 5;
  localparam int BIT_THERM_REG = 4;
  localparam int BIT_WDOG      = 3;
  localparam int BIT_CHARGE    = 0;
  localparam int BIT_PGOOD     = 7;
  localparam int BIT_SOURCE    = 4;
  localparam int BIT_THERMIST  = 2;
  localparam int BIT_OPTIMIZER = 1;
  localparam int BIT_OVERVOLT  = 7;
  localparam int BIT_SHUTDOWN  = 6;
  localparam int BIT_SAFETY    = 4;
  localparam int BIT_SNS_SHORT = 3;

  localparam time IRQ_PULSE_TIME_NS = 256ns;
  localparam int  CLK_PERIOD_NS     = 8;
  localparam int  IRQ_PULSE_CYCLES  =
    (256 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       adc_done;
    logic       in_cur_reg;
    logic       in_volt_reg;
    logic       therm_reg;
    logic       host_watchdog_expired_state;
    logic [2:0] charge_state_field;
    logic       power_good;
    logic [2:0] input_source_state_field;
    logic [2:0] thermistor_state_field;
    logic       current_optimizer_state;
    logic       overvolt;
    logic       shutdown;
    logic       safety_timer;
    logic       sense_short;
  } charger_status_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [hdl/charger_event_irq_masking.sv]
// charger event detection, sticky flags, masks and host interrupt pulse
// How it works
// - adc one-shot done pulses interrupt unless bit 7 of mask a is set
// - input current limit entry pulses interrupt unless mask a bit 6 set
// - input voltage limit entry pulses interrupt unless mask a bit 5 set
// - thermal regulation entry pulses interrupt unless mask a bit 4 set
// - watchdog expiry rising edge pulses interrupt unless mask a bit 3 set
// - charge state field change pulses interrupt unless mask a bit 0 set
// - power good toggle pulses interrupt unless mask b bit 7 set
// - input source field change pulses interrupt unless mask b bit 4 set
// - thermistor field change pulses interrupt unless mask b bit 2 set
// - optimizer rising edge pulses interrupt unless mask b bit 1 set
// - overvoltage rising edge pulses interrupt unless fault mask bit 7 set
// - thermal shutdown rising edge pulses unless fault mask bit 6 set
// - safety timer expiry edge pulses unless fault mask bit 4 set
// - sense short rising edge pulses unless fault mask bit 3 set
// - reserved mask bits read zero and ignore writes
// - masks clear on reset and register reset, not on watchdog expiry
// - event flags set on detection regardless of mask
// - safety timer expiry has its own fault flag bit
`timescale 1ns/1ps
module charger_event_irq_masking #(
  parameter int PULSE_CYCLES = irq_mask_pkg::IRQ_PULSE_CYCLES
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  input  wire logic                          clk_en,
  input  wire irq_mask_pkg::reg_req_t        req,
  input  wire logic                          reg_reset,
  input  wire irq_mask_pkg::charger_status_t status,
  output logic [7:0]                         rdata,
  output logic                               rvalid,
  output logic                               irq_pulse
);

  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535)
      $error("PULSE_CYCLES out of range");
  end

  // status arrives from analog sources: three stage sync, change accepted
  // only when the second and third stages agree
  localparam int SW = $bits(irq_mask_pkg::charger_status_t);
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] stable;
  logic [SW-1:0] prev;
  logic          primed;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (clk_en) begin
      sync1 <= status;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_filt
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          stable[g] <= 1'b0;
        end else if (clk_en && sync2[g] == sync3[g]) begin
          stable[g] <= sync3[g];
        end
      end
    end
  endgenerate

  // history starts from the reset-cleared filter, so a nonzero status at power-up still makes events
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prev   <= '0;
      primed <= 1'b0;
    end else if (clk_en) begin
      prev   <= stable;
      primed <= 1'b1;
    end
  end

  irq_mask_pkg::charger_status_t cur;
  irq_mask_pkg::charger_status_t old;
  assign cur = stable;
  assign old = prev;

  function automatic logic rose(input logic n, input logic o);
    return n & ~o;
  endfunction

  logic [7:0] ev_a;
  logic [7:0] ev_b;
  logic [7:0] ev_f;

  always_comb begin
    ev_a = 8'h00;
    ev_b = 8'h00;
    ev_f = 8'h00;
    if (primed) begin
      ev_a[irq_mask_pkg::BIT_ADC_DONE] = rose(cur.adc_done, old.adc_done);
      ev_a[irq_mask_pkg::BIT_IN_CUR] =
        rose(cur.in_cur_reg, old.in_cur_reg);
      ev_a[irq_mask_pkg::BIT_IN_VOLT] =
        rose(cur.in_volt_reg, old.in_volt_reg);
      ev_a[irq_mask_pkg::BIT_THERM_REG] = rose(cur.therm_reg, old.therm_reg);
      ev_a[irq_mask_pkg::BIT_WDOG] = rose(cur.host_watchdog_expired_state,
        old.host_watchdog_expired_state);
      ev_a[irq_mask_pkg::BIT_CHARGE] =
        cur.charge_state_field != old.charge_state_field;
      ev_b[irq_mask_pkg::BIT_PGOOD] = cur.power_good != old.power_good;
      ev_b[irq_mask_pkg::BIT_SOURCE] =
        cur.input_source_state_field != old.input_source_state_field;
      ev_b[irq_mask_pkg::BIT_THERMIST] =
        cur.thermistor_state_field != old.thermistor_state_field;
      ev_b[irq_mask_pkg::BIT_OPTIMIZER] = rose(cur.current_optimizer_state,
        old.current_optimizer_state);
      ev_f[irq_mask_pkg::BIT_OVERVOLT] = rose(cur.overvolt, old.overvolt);
      ev_f[irq_mask_pkg::BIT_SHUTDOWN] = rose(cur.shutdown, old.shutdown);
      ev_f[irq_mask_pkg::BIT_SAFETY] =
        rose(cur.safety_timer, old.safety_timer);
      ev_f[irq_mask_pkg::BIT_SNS_SHORT] =
        rose(cur.sense_short, old.sense_short);
    end
  end

  logic [7:0] charger_event_mask_a;
  logic [7:0] charger_event_mask_b;
  logic [7:0] fault_event_mask;
  logic [7:0] flag_a;
  logic [7:0] flag_b;
  logic [7:0] flag_f;

  // no watchdog input here: expiry cannot touch the masks
  always_ff @(posedge sys_clk) begin
    if (!rstn || (clk_en && reg_reset)) begin
      charger_event_mask_a <= irq_mask_pkg::RESET_MASK_A;
      charger_event_mask_b <= irq_mask_pkg::RESET_MASK_B;
      fault_event_mask     <= irq_mask_pkg::RESET_MASK_F;
    end else if (clk_en && req.wr_en) begin
      case (req.addr)
        irq_mask_pkg::ADDR_MASK_A:
          charger_event_mask_a <= req.wdata & irq_mask_pkg::USED_A;
        irq_mask_pkg::ADDR_MASK_B:
          charger_event_mask_b <= req.wdata & irq_mask_pkg::USED_B;
        irq_mask_pkg::ADDR_MASK_F:
          fault_event_mask <= req.wdata & irq_mask_pkg::USED_F;
        default: ;
      endcase
    end
  end

  // flags clear on read; a new event in the read cycle still sets the flag
  logic rd_fa;
  logic rd_fb;
  logic rd_ff;
  assign rd_fa = req.rd_en && req.addr == irq_mask_pkg::ADDR_FLAG_A;
  assign rd_fb = req.rd_en && req.addr == irq_mask_pkg::ADDR_FLAG_B;
  assign rd_ff = req.rd_en && req.addr == irq_mask_pkg::ADDR_FLAG_F;

  always_ff @(posedge sys_clk) begin
    if (!rstn || (clk_en && reg_reset)) begin
      flag_a <= 8'h00;
      flag_b <= 8'h00;
      flag_f <= 8'h00;
    end else if (clk_en) begin
      flag_a <= (rd_fa ? 8'h00 : flag_a) | ev_a;
      flag_b <= (rd_fb ? 8'h00 : flag_b) | ev_b;
      flag_f <= (rd_ff ? 8'h00 : flag_f) | ev_f;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else if (clk_en) begin
      rvalid <= req.rd_en;
      if (req.rd_en) begin
        case (req.addr)
          irq_mask_pkg::ADDR_MASK_A: rdata <= charger_event_mask_a;
          irq_mask_pkg::ADDR_MASK_B: rdata <= charger_event_mask_b;
          irq_mask_pkg::ADDR_MASK_F: rdata <= fault_event_mask;
          irq_mask_pkg::ADDR_FLAG_A: rdata <= flag_a;
          irq_mask_pkg::ADDR_FLAG_B: rdata <= flag_b;
          irq_mask_pkg::ADDR_FLAG_F: rdata <= flag_f;
          default:                   rdata <= 8'h00;
        endcase
      end
    end
  end

  // adc bit covers one-shot completion; the source pulses only then
  logic       fire;
  logic [7:0] live_a;
  assign live_a = ev_a & ~charger_event_mask_a;
  assign fire = |live_a
              | |(ev_b & ~charger_event_mask_b)
              | |(ev_f & ~fault_event_mask);

  // a new event during a pulse restarts the width rather than stacking
  logic [15:0] pulse_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pulse_cnt <= 16'h0000;
      irq_pulse <= 1'b0;
    end else if (clk_en) begin
      if (fire) begin
        pulse_cnt <= 16'(PULSE_CYCLES - 1);
        irq_pulse <= 1'b1;
      end else if (pulse_cnt != 16'h0000) begin
        pulse_cnt <= pulse_cnt - 16'h0001;
      end else begin
        irq_pulse <= 1'b0;
      end
    end
  end

endmodule

// [verif/irq_mask_assertions.sv]
// port-level assertions for the charger event interrupt masking block
`timescale 1ns/1ps
module irq_mask_assertions #(
  parameter int PULSE_CYCLES = 2
) (
  input wire logic                          sys_clk,
  input wire logic                          rstn,
  input wire logic                          clk_en,
  input wire irq_mask_pkg::reg_req_t        req,
  input wire logic                          reg_reset,
  input wire irq_mask_pkg::charger_status_t status,
  input wire logic [7:0]                    rdata,
  input wire logic                          rvalid,
  input wire logic                          irq_pulse
);
  int run;
  int quiet;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // quiet counts edges since the status inputs last moved
  always_ff @(posedge sys_clk) begin
    run <= irq_pulse ? run + 1 : 0;
    quiet <= $stable(status) ? quiet + 1 : 0;
  end
  chk_read_answer: assert property (
    req.rd_en && clk_en |=> rvalid) else $error("read not answered");
  chk_valid_cause: assert property (
    rvalid |-> $past(req.rd_en)) else $error("rvalid without read");
  chk_resv_a_zero: assert property (
    rvalid && $past(req.addr) inside {8'h12, 8'h0f} |->
    (rdata & ~irq_mask_pkg::USED_A) == 8'h00) else $error("reserved a");
  chk_resv_b_zero: assert property (
    rvalid && $past(req.addr) inside {8'h13, 8'h10} |->
    (rdata & ~irq_mask_pkg::USED_B) == 8'h00) else $error("reserved b");
  chk_resv_f_zero: assert property (
    rvalid && $past(req.addr) inside {8'h14, 8'h11} |->
    (rdata & ~irq_mask_pkg::USED_F) == 8'h00) else $error("reserved f");
  chk_unmapped_zero: assert property (
    rvalid && !($past(req.addr) inside {[8'h0f:8'h14]}) |->
    rdata == 8'h00) else $error("unmapped read nonzero");
  chk_pulse_width: assert property (
    $fell(irq_pulse) |-> run >= PULSE_CYCLES) else $error("pulse short");
  chk_pulse_cause: assert property (
    $rose(irq_pulse) |-> quiet <= 12) else $error("pulse without event");
  chk_reset_idle: assert property (
    $rose(rstn) |-> !irq_pulse && !rvalid && rdata == 8'h00)
    else $error("outputs not idle after reset");
  cover property ($rose(irq_pulse));
  cover property (rvalid && rdata != 8'h00);
  cover property (reg_reset);
endmodule
bind charger_event_irq_masking irq_mask_assertions #(
  .PULSE_CYCLES(PULSE_CYCLES)) i_chk (.sys_clk, .rstn, .clk_en, .req,
  .reg_reset, .status, .rdata, .rvalid, .irq_pulse);

// [verif/host_irq_model.sv]
// host side model: counts interrupt pulses and measures their width
`timescale 1ns/1ps
module host_irq_model (
  input  wire logic sys_clk,
  input  wire logic irq_pulse,
  output int        pulses,
  output int        width
);
  int   run  = 0;
  logic last = 1'b0;
  initial pulses = 0;
  initial width = 0;
  // the host counts a pulse on its rising edge only, as a pulse-triggered input, and records the width on the falling edge
  always @(posedge sys_clk) begin
    if (irq_pulse && !last) pulses <= pulses + 1;
    if (!irq_pulse && last) width <= run;
    run <= irq_pulse ? run + 1 : 0;
    last <= irq_pulse;
  end
endmodule

// [verif/charger_event_irq_masking_tb.sv]
// self-checking bench for the charger event interrupt masking block
`timescale 1ns/1ps
module charger_event_irq_masking_tb;
  localparam int PW = 4;
  localparam logic [7:0] USED [3] = '{8'hf9, 8'h96, 8'hd8};
  localparam int SB [14] =
    '{19, 18, 17, 16, 15, 12, 11, 8, 5, 4, 3, 2, 1, 0};
  localparam logic [7:0] RG [14] =
    '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2};
  localparam int MB [14] = '{7, 6, 5, 4, 3, 0, 7, 4, 2, 1, 7, 6, 4, 3};
  logic                          sys_clk   = 1'b0;
  logic                          rstn      = 1'b0;
  logic                          reg_reset = 1'b0;
  irq_mask_pkg::reg_req_t        req       = '0;
  irq_mask_pkg::charger_status_t status    = '0;
  logic [7:0]                    rdata;
  logic                          rvalid;
  logic                          irq_pulse;
  logic [7:0]                    got;
  logic [7:0]                    m;
  int                            pulses;
  int                            width;
  int                            base;
  int                            err_count = 0;
  int                            checked   = 0;
  charger_event_irq_masking #(
    .PULSE_CYCLES(PW)
  ) i_charger_event_irq_masking (
    .sys_clk, .rstn, .clk_en(1'b1), .req, .reg_reset, .status, .rdata,
    .rvalid, .irq_pulse);
  host_irq_model i_host_irq_model (.sys_clk, .irq_pulse, .pulses, .width);
  task automatic conclude();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    req.wr_en = 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    int k;
    @(negedge sys_clk);
    req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    req.rd_en = 1'b0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge sys_clk);
    if (k == 4) begin
      err_count++;
      conclude();
    end
    got = rdata;
  endtask
  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(61473));
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    // let the status synchroniser settle before any event is made
    repeat (8) @(negedge sys_clk);
    for (int r = 0; r < 3; r++) begin
      rd(8'h12 + 8'(r));
      cmp("mask reset", 8'h00, got);
      wr(8'h12 + 8'(r), 8'hff);
      rd(8'h12 + 8'(r));
      cmp("mask used bits", USED[r], got);
    end
    wr(8'h20, 8'hff);
    rd(8'h20);
    cmp("unmapped", 8'h00, got);
    for (int i = 0; i < 14; i++) begin
      m = (i == 0) ? 8'h00 : 8'($urandom);
      wr(8'h12 + RG[i], m);
      base = pulses;
      status[SB[i]] = ~status[SB[i]];
      repeat (24) @(negedge sys_clk);
      cmp("pulses",
          8'(pulses - base),
          {7'h00, ~m[MB[i]]});
      rd(8'h0f + RG[i]);
      cmp("flag", 8'h01 << MB[i], got);
      wr(8'h12 + RG[i], 8'hff);
      status[SB[i]] = ~status[SB[i]];
      repeat (24) @(negedge sys_clk);
      rd(8'h0f + RG[i]);
    end
    cmp("pulse width", 8'(PW), 8'(width));
    reg_reset = 1'b1;
    @(negedge sys_clk);
    reg_reset = 1'b0;
    for (int r = 0; r < 3; r++) begin
      rd(8'h12 + 8'(r));
      cmp("mask after reg reset", 8'h00, got);
    end
    conclude();
  end
endmodule
